// file: src/rcp_pkg.sv
// constants, register map and types for the reverse charge protection control block
// assumes a 100 MHz block clock and comparator inputs that are asynchronous to it
//
// Summary of operation
// RULE1: enable bit turns on both pass transistors and watches reverse current.
// RULE2: current above lower limit, below upper, for slow window opens the path.
// RULE3: lower-limit excursions shorter than the slow window are tolerated.
// RULE4: current above upper limit longer than fast time opens the path.
// RULE5: any over-current trip clears enable and raises reverse over-current event.
// RULE6: backflow above threshold for debounce clears enable and raises backflow event.
// RULE7: enable cannot be set again until 1 ms after a backflow event.
// RULE8: writes of one to enable during lockout are ignored.
// RULE9: software waits 1 to 5 ms after backflow before re-enabling.
// RULE10: charge voltage regulator stays disabled while reverse mode is enabled.
// RULE11: 4-bit charge current code selects main charger current, 0000 is zero.
// RULE12: code 1111 drives pass path fully on and blocks the battery switch; pass_full_on is driven only while enable is clear.
// RULE13: 3-bit trickle code selects trickle current, 000 is zero.
// RULE14: debounce is a parameter; comparator inputs are synchronised first.
// RULE15: trip windows are counters restarting when their comparator drops.
package rcp_pkg;

    localparam int CLK_FREQ_MHZ = 100;
    localparam int SLOW_TRIP_WINDOW_US = 1000;
    localparam int FAST_TRIP_TIME_US = 100;
    localparam int BACKFLOW_DEBOUNCE_US = 100;
    localparam int LOCKOUT_US = 1000;
    localparam int SLOW_TRIP_CYCLES = SLOW_TRIP_WINDOW_US * CLK_FREQ_MHZ;
    localparam int FAST_TRIP_CYCLES = FAST_TRIP_TIME_US * CLK_FREQ_MHZ;
    localparam int BACKFLOW_CYCLES = BACKFLOW_DEBOUNCE_US * CLK_FREQ_MHZ;
    localparam int LOCKOUT_CYCLES = LOCKOUT_US * CLK_FREQ_MHZ;
    localparam int CNT_W = 20;

    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CURR_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CURR_CHARGE_LSB = 0;
    localparam int CURR_TRICKLE_LSB = 4;
    localparam int EVT_OVERCURRENT_BIT = 0;
    localparam int EVT_BACKFLOW_BIT = 1;
    localparam int STAT_LOCKOUT_BIT = 2;
    localparam int STAT_ENABLE_BIT = 3;

    localparam logic [3:0] CHARGE_CODE_RESET = 4'h0;
    localparam logic [2:0] TRICKLE_CODE_RESET = 3'h0;
    localparam logic [3:0] CHARGE_CODE_FULL_ON = 4'hf;
    localparam logic [1:0] EVENTS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    typedef struct packed {
        logic lower_limit;
        logic upper_limit;
        logic backflow;
    } sense_t;

    typedef struct packed {
        logic pass_gate_drive;
        logic pass_full_on;
        logic battery_switch_inhibit;
        logic charge_voltage_regulator_en;
        logic [3:0] charge_current_code;
        logic [2:0] trickle_current_code;
    } power_ctl_t;

endpackage

// file: src/reverse_charge_protection_control.sv
// reverse charge protection control: reverse-source enable, over-current and backflow trips,
// charge current code outputs, behind an apb slave
// assumes comparator levels arrive asynchronously and the analog path obeys power_ctl
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module reverse_charge_protection_control
    import rcp_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_TRIP_CYCLES,
    parameter int FAST_CYCLES = FAST_TRIP_CYCLES,
    parameter int DEBOUNCE_CYCLES = BACKFLOW_CYCLES,
    parameter int LOCK_CYCLES = LOCKOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sense_t sense_async,
    input wire logic charge_regulator_req,
    output power_ctl_t power_ctl,
    output logic irq
);

    sense_t sync1_q;
    sense_t sync2_q;
    logic enable_q;
    logic [3:0] charge_code_q;
    logic [2:0] trickle_code_q;
    logic [1:0] events_q;
    logic [1:0] mask_q;
    logic [CNT_W-1:0] slow_cnt_q;
    logic [CNT_W-1:0] fast_cnt_q;
    logic [CNT_W-1:0] back_cnt_q;
    logic [CNT_W-1:0] lock_cnt_q;
    logic slow_trip;
    logic fast_trip;
    logic back_trip;
    logic lockout;
    logic wr;
    logic rd;
    logic mapped;

    // two stages before any comparator level is timed [RULE14]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sense_async;
            sync2_q <= sync1_q;
        end
    end

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign mapped = (paddr == CTRL_ADDR) || (paddr == CURR_ADDR) ||
                    (paddr == STATUS_ADDR) || (paddr == IRQ_MASK_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // slow window: lower limit only, restarts when comparator drops or upper limit takes over
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_cnt_q <= '0;
        end else if (!enable_q || !sync2_q.lower_limit || sync2_q.upper_limit) begin
            slow_cnt_q <= '0; // [RULE15] [RULE3]
        end else if (!slow_trip) begin
            slow_cnt_q <= slow_cnt_q + 1'b1;
        end
    end
    assign slow_trip = slow_cnt_q == CNT_W'(SLOW_CYCLES); // [RULE2]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_cnt_q <= '0;
        end else if (!enable_q || !sync2_q.upper_limit) begin
            fast_cnt_q <= '0; // [RULE15]
        end else if (!fast_trip) begin
            fast_cnt_q <= fast_cnt_q + 1'b1;
        end
    end
    assign fast_trip = fast_cnt_q == CNT_W'(FAST_CYCLES); // [RULE4]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            back_cnt_q <= '0;
        end else if (!enable_q || !sync2_q.backflow) begin
            back_cnt_q <= '0;
        end else if (!back_trip) begin
            back_cnt_q <= back_cnt_q + 1'b1;
        end
    end
    assign back_trip = back_cnt_q == CNT_W'(DEBOUNCE_CYCLES); // [RULE6] [RULE14]

    // lockout runs from the cycle the backflow event is raised
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_cnt_q <= '0;
        end else if (enable_q && back_trip) begin
            lock_cnt_q <= CNT_W'(LOCK_CYCLES); // [RULE7]
        end else if (lock_cnt_q != '0) begin
            lock_cnt_q <= lock_cnt_q - 1'b1;
        end
    end
    assign lockout = lock_cnt_q != '0;

    // trips beat a same-cycle software set so a fault never leaves the path on
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_q <= 1'b0;
        end else if (enable_q && (slow_trip || fast_trip || back_trip)) begin
            enable_q <= 1'b0; // [RULE5] [RULE6]
        end else if (wr && paddr == CTRL_ADDR) begin
            // a one during lockout leaves the bit cleared [RULE8] [RULE7]
            enable_q <= pwdata[CTRL_ENABLE_BIT] && !lockout;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            charge_code_q <= CHARGE_CODE_RESET;
            trickle_code_q <= TRICKLE_CODE_RESET;
        end else if (wr && paddr == CURR_ADDR) begin
            charge_code_q <= pwdata[CURR_CHARGE_LSB +: 4]; // [RULE11]
            trickle_code_q <= pwdata[CURR_TRICKLE_LSB +: 3]; // [RULE13]
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            events_q <= EVENTS_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr && paddr == STATUS_ADDR && pwdata[i]) begin
                    events_q[i] <= 1'b0;
                end
            end
            if (enable_q && (slow_trip || fast_trip)) begin
                events_q[EVT_OVERCURRENT_BIT] <= 1'b1; // [RULE5]
            end
            if (enable_q && back_trip) begin
                events_q[EVT_BACKFLOW_BIT] <= 1'b1; // [RULE6]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= MASK_RESET;
        end else if (wr && paddr == IRQ_MASK_ADDR) begin
            mask_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(events_q & mask_q);
        end
    end

    // registered power controls so the analog side sees clean levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_ctl <= '0;
        end else begin
            power_ctl.pass_gate_drive <= enable_q; // [RULE1]
            power_ctl.pass_full_on <= !enable_q &&
                                      charge_code_q == CHARGE_CODE_FULL_ON; // [RULE12]
            power_ctl.battery_switch_inhibit <= charge_code_q == CHARGE_CODE_FULL_ON; // [RULE12]
            power_ctl.charge_voltage_regulator_en <= charge_regulator_req && !enable_q; // [RULE10]
            power_ctl.charge_current_code <= charge_code_q; // [RULE11]
            power_ctl.trickle_current_code <= trickle_code_q; // [RULE13]
        end
    end

    always_comb begin
        prdata = '0;
        if (rd) begin
            case (paddr)
                CTRL_ADDR: prdata[CTRL_ENABLE_BIT] = enable_q;
                CURR_ADDR: begin
                    prdata[CURR_CHARGE_LSB +: 4] = charge_code_q;
                    prdata[CURR_TRICKLE_LSB +: 3] = trickle_code_q;
                end
                STATUS_ADDR: begin
                    prdata[1:0] = events_q;
                    prdata[STAT_LOCKOUT_BIT] = lockout;
                    prdata[STAT_ENABLE_BIT] = enable_q;
                end
                IRQ_MASK_ADDR: prdata[1:0] = mask_q;
                default: prdata = '0;
            endcase
        end
    end

endmodule

// file: testbench/accessory_model.sv
// powered accessory on the reverse path, turning a commanded load into comparator levels
// assumes the bench changes load_mode just after a rising edge
`timescale 1ns/100ps
module accessory_model
    import rcp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic path_on,
    input wire logic [1:0] load_mode,
    output sense_t sense
);
    // no current flows, either way, once the pass path is open
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sense <= '0;
        end else begin
            sense.lower_limit <= path_on && (load_mode == 2'h1 || load_mode == 2'h2);
            sense.upper_limit <= path_on && load_mode == 2'h2;
            sense.backflow <= path_on && load_mode == 2'h3;
        end
    end
endmodule

// file: testbench/rcp_checker_sva.sv
// port assertions for the reverse charge protection control block
// assumes the bind hands on the trip window parameters of the instance
`timescale 1ns/100ps
module rcp_checker
    import rcp_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_TRIP_CYCLES,
    parameter int FAST_CYCLES = FAST_TRIP_CYCLES,
    parameter int DEBOUNCE_CYCLES = BACKFLOW_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire sense_t sense_async,
    input wire power_ctl_t power_ctl
);
    int slow_n, fast_n, back_n;
    logic gate, wr;
    assign gate = power_ctl.pass_gate_drive;
    assign wr = psel && penable && pwrite;
    // cycles of raw overload seen while the path is on; two sync flops allow a small slack
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_n <= 0;
            fast_n <= 0;
            back_n <= 0;
        end else begin
            slow_n <= (gate && sense_async.lower_limit && !sense_async.upper_limit) ? slow_n + 1 : 0;
            fast_n <= (gate && sense_async.upper_limit) ? fast_n + 1 : 0;
            back_n <= (gate && sense_async.backflow) ? back_n + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_SLOW_TRIP: assert property (slow_n <= SLOW_CYCLES + 5)
        else $error("slow trip late");
    AST_FAST_TRIP: assert property (fast_n <= FAST_CYCLES + 5)
        else $error("fast trip late");
    AST_BACKFLOW_TRIP: assert property (back_n <= DEBOUNCE_CYCLES + 5)
        else $error("backflow trip late");
    AST_ENABLE_SOURCE: assert property ($rose(gate) |->
        $past(wr && paddr == CTRL_ADDR && pwdata[CTRL_ENABLE_BIT], 2)) else $error("gate rose alone");
    AST_CHARGE_CODE: assert property (wr && paddr == CURR_ADDR |->
        ##2 power_ctl.charge_current_code == $past(pwdata[3:0], 2)) else $error("charge code");
    AST_TRICKLE_CODE: assert property (wr && paddr == CURR_ADDR |->
        ##2 power_ctl.trickle_current_code == $past(pwdata[6:4], 2)) else $error("trickle code");
    AST_REG_OFF: assert property (gate |-> !power_ctl.charge_voltage_regulator_en)
        else $error("regulator on in reverse mode");
    AST_FULL_ON: assert property (power_ctl.battery_switch_inhibit ==
        (power_ctl.charge_current_code == CHARGE_CODE_FULL_ON)) else $error("switch inhibit");
endmodule
bind reverse_charge_protection_control rcp_checker #(.SLOW_CYCLES(SLOW_CYCLES),
    .FAST_CYCLES(FAST_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) rcp_checker_inst (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .sense_async(sense_async), .power_ctl(power_ctl));

// file: testbench/testbench.sv
// self-checking bench: apb calls with expected values, the accessory model drives the comparators
// assumes shortened trip windows so that every count fits in a short run
`timescale 1ns/100ps
module testbench
    import rcp_pkg::*;
;
    localparam int SL = 20, FA = 8, DB = 5, LK = 30;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, rd_err;
    logic [1:0] load = 2'h0;
    sense_t sense;
    power_ctl_t pc;
    int n_mismatch = 0, n_compared = 0;
    reverse_charge_protection_control #(.SLOW_CYCLES(SL), .FAST_CYCLES(FA),
        .DEBOUNCE_CYCLES(DB), .LOCK_CYCLES(LK)) reverse_charge_protection_control_inst (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_async(sense),
        .charge_regulator_req(req), .power_ctl(pc), .irq(irq));
    accessory_model accessory_model_inst (.clk(clk), .rst_b(rst_b), .path_on(pc.pass_gate_drive),
        .load_mode(load), .sense(sense));
    initial forever #5 clk = ~clk;
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one idle edge after release keeps back-to-back calls from driving psel twice at one time
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            n_mismatch++;
            report_and_stop();
        end
        @(posedge clk);
    endtask
    initial begin
        cyc(2);
        rst_b <= 1'b1;
        cyc(1);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk(rd_err, 1'b1);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, CURR_ADDR, {25'h0, i[2:0], i[3:0]});
            cyc(1);
            chk(pc.charge_current_code, i[3:0]);
            chk(pc.trickle_current_code, i[2:0]);
            chk({pc.pass_full_on, pc.battery_switch_inhibit}, {2{i == 15}});
        end
        $display("test codes done");
        req <= 1'b1;
        apb(1'b1, CTRL_ADDR, 32'h1);
        cyc(1);
        chk({pc.pass_gate_drive, pc.charge_voltage_regulator_en}, 2'b10);
        load <= 2'h1;
        cyc(SL - 5);
        load <= 2'h0;
        cyc(5);
        chk(pc.pass_gate_drive, 1'b1);
        load <= 2'h1;
        cyc(SL + 10);
        chk({pc.pass_gate_drive, pc.charge_voltage_regulator_en}, 2'b01);
        load <= 2'h0;
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rd, 32'h1);
        chk(irq, 1'b0);
        apb(1'b1, IRQ_MASK_ADDR, 32'h3);
        cyc(1);
        chk(irq, 1'b1);
        apb(1'b1, STATUS_ADDR, 32'h1);
        cyc(1);
        chk(irq, 1'b0);
        $display("test slow trip done");
        apb(1'b1, CTRL_ADDR, 32'h1);
        load <= 2'h2;
        cyc(FA + 10);
        chk(pc.pass_gate_drive, 1'b0);
        load <= 2'h0;
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, STATUS_ADDR, 32'h1);
        $display("test fast trip done");
        apb(1'b1, CTRL_ADDR, 32'h1);
        load <= 2'h3;
        cyc(DB + 10);
        chk(pc.pass_gate_drive, 1'b0);
        load <= 2'h0;
        apb(1'b1, CTRL_ADDR, 32'h1);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rd, 32'h6);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk(pc.pass_gate_drive, 1'b0);
        cyc(LK);
        apb(1'b1, STATUS_ADDR, 32'h2);
        apb(1'b1, CTRL_ADDR, 32'h1);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h1);
        $display("test backflow done");
        report_and_stop();
    end
endmodule
